/* File: inc/flash_sec_pkg.sv */
// Shared constants for the serial flash security and protection-select link
package flash_sec_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_PERIOD_NS = 5;
  localparam int SCLK_PERIOD_NS = 125;
  // Longest half period that fits, rounded down
  localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  localparam int CS_GAP_CYCLES = 2 * SCLK_HALF_CYCLES;

  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int BLOCK_COUNT = 128;
  localparam int SECTORS_PER_BLOCK = 16;

  // ----------------------------------------
  // Opcodes (arbitrary values)
  // ----------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h11;
  localparam logic [7:0] OP_READ_SECURITY = 8'h22;
  localparam logic [7:0] OP_WRITE_SECURITY = 8'h33;
  localparam logic [7:0] OP_SCHEME_SELECT = 8'h44;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h55;

  // ----------------------------------------
  // Link framing
  // ----------------------------------------
  localparam logic [3:0] OPCODE_BYTES = 4'h1;
  localparam logic [3:0] PAGE_WRITE_BYTES = 4'h5;
  localparam logic [3:0] BYTE_COUNT_MAX = 4'hF;
  localparam logic [5:0] OPCODE_EDGES_SINGLE = 6'h08;
  localparam logic [5:0] OPCODE_EDGES_QUAD = 6'h02;
  localparam logic [2:0] LANES_SINGLE = 3'h1;
  localparam logic [2:0] LANES_QUAD = 3'h4;

  // ----------------------------------------
  // Security status fields and reset values
  // ----------------------------------------
  localparam int BIT_SCHEME = 7;
  localparam int BIT_ERASE_FAIL = 6;
  localparam int BIT_PROGRAM_FAIL = 5;
  localparam int BIT_RESERVED = 4;
  localparam int BIT_ERASE_SUSP = 3;
  localparam int BIT_PROGRAM_SUSP = 2;
  localparam int BIT_LOCKDOWN = 1;
  localparam int BIT_FACTORY_LOCK = 0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic DYNAMIC_RESET = 1'b1;

  // ----------------------------------------
  // Host register map (APB byte offsets)
  // ----------------------------------------
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_ADDRESS = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CMD_QUAD_BIT = 8;

  typedef enum logic [2:0] {
    KIND_WRITE_ENABLE = 3'h0,
    KIND_READ_SECURITY = 3'h1,
    KIND_WRITE_SECURITY = 3'h2,
    KIND_SCHEME_SELECT = 3'h3,
    KIND_PAGE_WRITE = 3'h4
  } cmd_kind_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_RUN = 3'b010,
    H_GAP = 3'b100
  } host_state_t;

endpackage : flash_sec_pkg

/* File: inc/flash_link_if.sv */
// Serial link between the host controller and the flash security logic
`timescale 1ns/100ps
interface flash_link_if;
  logic csN;
  logic sclk;
  logic [3:0] hostIo;
  logic [3:0] hostIoOe;
  logic [3:0] devIo;
  logic [3:0] devIoOe;
  logic [3:0] io;

  // Undriven lines float high as if pulled up
  assign io = (hostIoOe & hostIo) | (devIoOe & devIo) | ~(hostIoOe | devIoOe);

  modport host(output csN, output sclk, output hostIo, output hostIoOe, input io);
  modport device(input csN, input sclk, input io, output devIo, output devIoOe);
endinterface : flash_link_if

/* File: src/flash_sec_device.sv */
// Flash end: security status register and protection scheme selection
// Function
// - Security read answers anytime, repeating continuously
// - Read: select, opcode, status out, deselect
// - Opcode 8 single or 2 quad clocks
// - Security write needs write enable latch
// - Security write sets permanent OTP lockdown bit; here reset clears it
// - Deselect off byte boundary rejects command
// - Bit7 selects block or per-sector protection
// - Erase fail flag follows last erase
// - Program fail flag follows last program
// - Erase suspended flag set/cleared by resume
// - Program suspended flag set/cleared by resume
// - Bit0 factory lock indicator, bit4 reserved
// - OTP mode blocks main array access
// - Select command sets scheme bit permanently; here reset clears it
// - Scheme 0 uses block protect level
// - Scheme 1 ignores level, enables lock commands
// - Scheme 1 write-protect pin low locks all
// - Dynamic bits all protected after power-up
// - Solid and dynamic bit per region
// - Either bit set inhibits program/erase
// - Solid bits stay modifiable after reset
// - Protected target refuses page write
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module flash_sec_device
  import flash_sec_pkg::*;
#(
  parameter int BLOCKS = BLOCK_COUNT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial link
  flash_link_if.device link,
  // Mode and protection inputs
  input wire logic quadMode,
  input wire logic otpMode,
  input wire logic wpN,
  input wire logic [3:0] blockProtectLevel,
  input wire logic factoryLock,
  // Array operation events
  input wire logic [23:0] eraseAddr,
  input wire logic eraseDone,
  input wire logic eraseOk,
  input wire logic programDone,
  input wire logic programOk,
  input wire logic eraseSuspend,
  input wire logic eraseResume,
  input wire logic programSuspend,
  input wire logic programResume,
  // Per-region lock requests
  input wire logic [23:0] lockAddr,
  input wire logic solidSet,
  input wire logic solidClearAll,
  input wire logic dynamicWrite,
  input wire logic dynamicValue,
  input wire logic gangLock,
  input wire logic gangUnlock,
  // Status and array requests
  output logic [7:0] securityStatus,
  output logic writeEnableLatch,
  output logic advancedCmdsEnabled,
  output logic arrayAccessOk,
  output logic otpWritable,
  output logic eraseProtected,
  output logic writeStart,
  output logic [23:0] writeAddr,
  output logic [7:0] writeData
);

  localparam int REGIONS = BLOCKS - 2 + 2 * SECTORS_PER_BLOCK;

  // ----------------------------------------
  // Link synchronisers
  // ----------------------------------------
  logic csS1, csS2, csPrev;
  logic sclkS1, sclkS2, sclkPrev;
  logic [3:0] ioS1, ioS2;

  always_ff @(posedge mclk) begin
    if (rst) begin
      {csS1, csS2, csPrev} <= 3'h7;
      {sclkS1, sclkS2, sclkPrev} <= 3'h0;
      ioS1 <= 4'hF;
      ioS2 <= 4'hF;
    end else begin
      csS1 <= link.csN;
      csS2 <= csS1;
      csPrev <= csS2;
      sclkS1 <= link.sclk;
      sclkS2 <= sclkS1;
      sclkPrev <= sclkS2;
      ioS1 <= link.io;
      ioS2 <= ioS1;
    end
  end

  logic csRise, sclkRise, sclkFall;
  logic [2:0] step;
  assign csRise = csS2 & ~csPrev;
  assign sclkRise = ~csS2 & sclkS2 & ~sclkPrev;
  assign sclkFall = ~csS2 & ~sclkS2 & sclkPrev;
  assign step = quadMode ? LANES_QUAD : LANES_SINGLE;

  // ----------------------------------------
  // Command receive
  // ----------------------------------------
  logic [7:0] inShift, next_inShift, opcode;
  logic [2:0] bitCnt, next_bitCnt;
  logic [3:0] byteCnt;
  logic byteDone;

  // Single-line mode looks at the first data line only
  assign next_inShift = quadMode ? {inShift[3:0], ioS2} : {inShift[6:0], ioS2[0]};
  assign next_bitCnt = 3'(bitCnt + step);
  assign byteDone = sclkRise & (next_bitCnt == 3'h0);

  always_ff @(posedge mclk) begin
    if (rst) begin
      inShift <= 8'h00;
      opcode <= 8'h00;
      writeAddr <= 24'h000000;
      writeData <= 8'h00;
    end else if (sclkRise) begin
      inShift <= next_inShift;
      if (byteDone) begin
        case (byteCnt)
          4'h0: opcode <= next_inShift;
          4'h1: writeAddr[23:16] <= next_inShift;
          4'h2: writeAddr[15:8] <= next_inShift;
          4'h3: writeAddr[7:0] <= next_inShift;
          4'h4: writeData <= next_inShift;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || csS2) begin
      bitCnt <= 3'h0;
      byteCnt <= 4'h0;
    end else if (sclkRise) begin
      bitCnt <= next_bitCnt;
      if (byteDone && byteCnt != BYTE_COUNT_MAX)
        byteCnt <= byteCnt + 4'h1;
    end
  end

  // ----------------------------------------
  // Protection decision
  // ----------------------------------------
  logic scheme, wpS1, wpS2;
  logic [REGIONS-1:0] solid, dynamic;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wpS1 <= 1'b1;
      wpS2 <= 1'b1;
    end else begin
      wpS1 <= wpN;
      wpS2 <= wpS1;
    end
  end

  // Small sectors in the bottom and top block, whole blocks elsewhere
  function automatic int regionIndex(input logic [23:0] a);
    int blk;
    blk = int'(a[23:16]);
    if (blk == 0)
      return int'(a[15:12]);
    else if (blk >= BLOCKS - 1)
      return BLOCKS + SECTORS_PER_BLOCK - 2 + int'(a[15:12]);
    return SECTORS_PER_BLOCK - 1 + blk;
  endfunction : regionIndex

  // Level n guards the top 2^(n-1) blocks; eight or more guards all
  function automatic logic levelProtects(input logic [3:0] lvl, input logic [23:0] a);
    if (lvl == 4'h0)
      return 1'b0;
    else if (lvl >= 4'h8)
      return 1'b1;
    return int'(a[23:16]) >= BLOCKS - (1 << (int'(lvl) - 1));
  endfunction : levelProtects

  function automatic logic isProtected(input logic [23:0] a);
    int idx;
    idx = regionIndex(a);
    if (scheme)
      return ~wpS2 | solid[idx] | dynamic[idx];
    return levelProtects(blockProtectLevel, a);
  endfunction : isProtected

  assign advancedCmdsEnabled = scheme;
  assign arrayAccessOk = ~otpMode;
  // Process form so scheme, pin and lock bits read inside the function wake it
  always_comb eraseProtected = isProtected(eraseAddr);

  // Lock requests only count once per-sector protection is selected
  always_ff @(posedge mclk) begin
    if (rst)
      solid <= '0;
    else if (scheme && solidClearAll)
      solid <= '0;
    else if (scheme && solidSet)
      solid[regionIndex(lockAddr)] <= 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (rst)
      dynamic <= {REGIONS{DYNAMIC_RESET}};
    else if (scheme && gangLock)
      dynamic <= '1;
    else if (scheme && gangUnlock)
      dynamic <= '0;
    else if (scheme && dynamicWrite)
      dynamic[regionIndex(lockAddr)] <= dynamicValue;
  end

  // ----------------------------------------
  // Command execution at deselect
  // ----------------------------------------
  logic onBoundary, execWren, execSecWrite, execSelect, execPage, pageRefused;
  logic lockdown, factoryLockBit;

  assign onBoundary = csRise & (bitCnt == 3'h0);
  assign execWren = onBoundary & (byteCnt == OPCODE_BYTES) & (opcode == OP_WRITE_ENABLE);
  assign execSecWrite = onBoundary & (byteCnt == OPCODE_BYTES) & (opcode == OP_WRITE_SECURITY)
    & writeEnableLatch;
  assign execSelect = onBoundary & (byteCnt == OPCODE_BYTES) & (opcode == OP_SCHEME_SELECT)
    & writeEnableLatch;
  assign execPage = onBoundary & (byteCnt >= PAGE_WRITE_BYTES) & (opcode == OP_PAGE_WRITE)
    & writeEnableLatch & ~otpMode;
  always_comb pageRefused = execPage & isProtected(writeAddr);

  always_ff @(posedge mclk) begin
    if (rst)
      writeEnableLatch <= 1'b0;
    else if (execWren)
      writeEnableLatch <= 1'b1;
    else if (execSecWrite || execSelect || execPage)
      writeEnableLatch <= 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lockdown <= FLAG_RESET;
      scheme <= FLAG_RESET;
    end else begin
      if (execSecWrite)
        lockdown <= 1'b1;
      if (execSelect)
        scheme <= 1'b1;
    end
  end

  assign otpWritable = ~lockdown;

  always_ff @(posedge mclk) begin
    if (rst)
      writeStart <= 1'b0;
    else
      writeStart <= execPage & ~pageRefused;
  end

  // Strap captured while reset is held
  always_ff @(posedge mclk) begin
    if (rst)
      factoryLockBit <= factoryLock;
  end

  // ----------------------------------------
  // Operation flags
  // ----------------------------------------
  logic eraseFail, programFail, eraseSusp, programSusp;

  always_ff @(posedge mclk) begin
    if (rst) begin
      eraseFail <= FLAG_RESET;
      programFail <= FLAG_RESET;
    end else begin
      if (eraseDone)
        eraseFail <= ~eraseOk | eraseProtected;
      if (pageRefused)
        programFail <= 1'b1;
      else if (programDone)
        programFail <= ~programOk;
    end
  end

  // Suspend wins over a resume in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      eraseSusp <= FLAG_RESET;
      programSusp <= FLAG_RESET;
    end else begin
      if (eraseSuspend)
        eraseSusp <= 1'b1;
      else if (eraseResume)
        eraseSusp <= 1'b0;
      if (programSuspend)
        programSusp <= 1'b1;
      else if (programResume)
        programSusp <= 1'b0;
    end
  end

  always_comb begin
    securityStatus = 8'h00;
    securityStatus[BIT_SCHEME] = scheme;
    securityStatus[BIT_ERASE_FAIL] = eraseFail;
    securityStatus[BIT_PROGRAM_FAIL] = programFail;
    securityStatus[BIT_ERASE_SUSP] = eraseSusp;
    securityStatus[BIT_PROGRAM_SUSP] = programSusp;
    securityStatus[BIT_LOCKDOWN] = lockdown;
    securityStatus[BIT_FACTORY_LOCK] = factoryLockBit;
  end

  // ----------------------------------------
  // Security status read-out
  // ----------------------------------------
  logic reading;
  logic [7:0] outShift, outWord;
  logic [2:0] outCnt;

  // Reloaded live at every byte so a long read tracks flag changes
  assign outWord = (outCnt == 3'h0) ? securityStatus : outShift;

  always_ff @(posedge mclk) begin
    if (rst || csS2) begin
      reading <= 1'b0;
      outShift <= 8'h00;
      outCnt <= 3'h0;
      link.devIo <= 4'h0;
      link.devIoOe <= 4'h0;
    end else begin
      if (byteDone && byteCnt == 4'h0 && next_inShift == OP_READ_SECURITY)
        reading <= 1'b1;
      if (sclkFall && reading) begin
        link.devIo <= quadMode ? outWord[7:4] : {2'h0, outWord[7], 1'h0};
        link.devIoOe <= quadMode ? 4'hF : 4'h2;
        outShift <= quadMode ? {outWord[3:0], 4'h0} : {outWord[6:0], 1'h0};
        outCnt <= 3'(outCnt + step);
      end
    end
  end

endmodule : flash_sec_device

/* File: src/flash_sec_host.sv */
// Host end: APB-controlled serial command engine for the security commands
`timescale 1ns/100ps
module flash_sec_host
  import flash_sec_pkg::*;
#(
  parameter int HALF_CYCLES = SCLK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  flash_link_if.host link
);

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  host_state_t state;
  cmd_kind_t kind;
  logic quad, refused, welSent;
  logic [23:0] addrReg;
  logic [7:0] wdataReg, readByte;
  logic apbWrite, mapped, cmdWrite, needsWel, startCmd;
  cmd_kind_t reqKind;

  assign pready = 1'b1;
  assign mapped = (paddr[7:0] == REG_COMMAND) || (paddr[7:0] == REG_ADDRESS)
    || (paddr[7:0] == REG_WDATA) || (paddr[7:0] == REG_STATUS);
  assign pslverr = psel & penable & ~mapped;
  assign apbWrite = psel & penable & pwrite & mapped;
  assign cmdWrite = apbWrite & (paddr[7:0] == REG_COMMAND);
  assign reqKind = cmd_kind_t'(pwdata[2:0]);
  // Writes to the status word or the array need a fresh write enable first
  assign needsWel = (reqKind == KIND_WRITE_SECURITY) || (reqKind == KIND_SCHEME_SELECT)
    || (reqKind == KIND_PAGE_WRITE);
  assign startCmd = cmdWrite & (state == H_IDLE) & (~needsWel | welSent) & (pwdata[2:0] <= 3'h4);

  always_ff @(posedge mclk) begin
    if (rst) begin
      addrReg <= 24'h000000;
      wdataReg <= 8'h00;
      refused <= 1'b0;
      welSent <= 1'b0;
    end else begin
      if (apbWrite && paddr[7:0] == REG_ADDRESS)
        addrReg <= pwdata[23:0];
      if (apbWrite && paddr[7:0] == REG_WDATA)
        wdataReg <= pwdata[7:0];
      if (cmdWrite)
        refused <= ~startCmd;
      if (startCmd && reqKind == KIND_WRITE_ENABLE)
        welSent <= 1'b1;
      else if (startCmd && needsWel)
        welSent <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst)
      prdata <= 32'h00000000;
    else if (psel && !penable) begin
      if (paddr[7:0] == REG_COMMAND)
        prdata <= {23'h000000, quad, 5'h00, kind};
      else if (paddr[7:0] == REG_ADDRESS)
        prdata <= {8'h00, addrReg};
      else if (paddr[7:0] == REG_WDATA)
        prdata <= {24'h000000, wdataReg};
      else if (paddr[7:0] == REG_STATUS)
        prdata <= {16'h0000, readByte, 5'h00, welSent, refused, state != H_IDLE};
      else
        prdata <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // Link engine
  // ----------------------------------------
  logic [3:0] ioS1, ioS2;
  logic [39:0] tx, next_tx;
  logic [7:0] rx, opc;
  logic [5:0] edgeCnt, totalEdges, opEdges;
  logic [7:0] divCnt;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ioS1 <= 4'hF;
      ioS2 <= 4'hF;
    end else begin
      ioS1 <= link.io;
      ioS2 <= ioS1;
    end
  end

  function automatic logic [7:0] opcodeOf(input cmd_kind_t k);
    case (k)
      KIND_WRITE_ENABLE: return OP_WRITE_ENABLE;
      KIND_READ_SECURITY: return OP_READ_SECURITY;
      KIND_WRITE_SECURITY: return OP_WRITE_SECURITY;
      KIND_SCHEME_SELECT: return OP_SCHEME_SELECT;
      default: return OP_PAGE_WRITE;
    endcase
  endfunction : opcodeOf

  // Clock edges per frame; every frame ends on a whole byte
  function automatic logic [5:0] edgesOf(input cmd_kind_t k, input logic q);
    logic [5:0] bits;
    bits = (k == KIND_PAGE_WRITE) ? 6'h28 : (k == KIND_READ_SECURITY) ? 6'h10 : 6'h08;
    return q ? (bits >> 2) : bits;
  endfunction : edgesOf

  assign opc = opcodeOf(reqKind);
  assign opEdges = quad ? OPCODE_EDGES_QUAD : OPCODE_EDGES_SINGLE;
  assign next_tx = quad ? {tx[35:0], 4'h0} : {tx[38:0], 1'h0};

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= H_IDLE;
      kind <= KIND_WRITE_ENABLE;
      quad <= 1'b0;
      tx <= 40'h0000000000;
      rx <= 8'h00;
      readByte <= 8'h00;
      edgeCnt <= 6'h00;
      totalEdges <= 6'h00;
      divCnt <= 8'h00;
      link.csN <= 1'b1;
      link.sclk <= 1'b0;
      link.hostIo <= 4'h0;
      link.hostIoOe <= 4'h0;
    end else begin
      case (state)
        H_IDLE: begin
          if (startCmd) begin
            kind <= reqKind;
            quad <= pwdata[CMD_QUAD_BIT];
            tx <= {opc, addrReg, wdataReg};
            totalEdges <= edgesOf(reqKind, pwdata[CMD_QUAD_BIT]);
            edgeCnt <= 6'h00;
            divCnt <= 8'h00;
            link.csN <= 1'b0;
            link.hostIo <= pwdata[CMD_QUAD_BIT] ? opc[7:4] : {3'h0, opc[7]};
            link.hostIoOe <= pwdata[CMD_QUAD_BIT] ? 4'hF : 4'h1;
            state <= H_RUN;
          end
        end
        H_RUN: begin
          if (divCnt == 8'(HALF_CYCLES - 1)) begin
            divCnt <= 8'h00;
            link.sclk <= ~link.sclk;
            if (!link.sclk) begin
              edgeCnt <= edgeCnt + 6'h01;
              if (kind == KIND_READ_SECURITY && edgeCnt >= opEdges)
                rx <= quad ? {rx[3:0], ioS2} : {rx[6:0], ioS2[1]};
            end else if (edgeCnt == totalEdges) begin
              link.csN <= 1'b1;
              link.hostIoOe <= 4'h0;
              divCnt <= 8'h00;
              state <= H_GAP;
            end else begin
              tx <= next_tx;
              link.hostIo <= quad ? next_tx[39:36] : {3'h0, next_tx[39]};
              if (kind == KIND_READ_SECURITY && edgeCnt >= opEdges)
                link.hostIoOe <= 4'h0;
            end
          end else begin
            divCnt <= divCnt + 8'h01;
          end
        end
        H_GAP: begin
          if (divCnt == 8'(CS_GAP_CYCLES - 1)) begin
            if (kind == KIND_READ_SECURITY)
              readByte <= rx;
            state <= H_IDLE;
          end else begin
            divCnt <= divCnt + 8'h01;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

endmodule : flash_sec_host

/* File: test/flash_link_sva.sv */
// Protocol checker for the flash security serial link
`timescale 1ns/100ps
module flash_link_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] hostIoOe,
  input wire logic [3:0] devIo,
  input wire logic [3:0] devIoOe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ------------------------------
  // Link rules
  // ------------------------------
  clk_idle_low_a: assert property (csN |-> !sclk)
    else $error("clock high while deselected");
  select_edge_a: assert property ($fell(csN) |-> !sclk)
    else $error("select fell with clock high");
  frame_gap_a: assert property ($rose(csN) |=> csN[*8])
    else $error("frame gap too short");
  clk_high_a: assert property ($rose(sclk) |-> sclk[*8])
    else $error("clock high phase too short");
  clk_low_a: assert property ($fell(sclk) && !csN |-> (!sclk)[*8])
    else $error("clock low phase too short");
  no_fight_a: assert property ((hostIoOe & devIoOe) == 4'h0)
    else $error("both ends drive one line");
  dev_release_a: assert property (csN[*8] |-> devIoOe == 4'h0)
    else $error("device drives while deselected");
  host_release_a: assert property (csN && $past(csN) |-> hostIoOe == 4'h0)
    else $error("host drives between frames");
  dev_launch_a: assert property (devIoOe != 4'h0 && $changed(devIo) |-> !sclk)
    else $error("device data moved in clock high phase");
  cover property ($rose(devIoOe[1]));
  cover property ($rose(devIoOe[3]));
  cover property ($rose(csN));
endmodule : flash_link_sva

/* File: test/test_flash_security_protect_select.sv */
// Self-checking bench joining the host and device ends of the security link
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("unexpected %0t %0h %0h", $time, (a), (e)); end end
module test_flash_security_protect_select;
  import flash_sec_pkg::*;
  typedef struct packed {logic [2:0] kind; logic quad; logic [7:0] sec; logic write_enable_latch;} row_t;
  typedef struct packed {logic [3:0] idx; logic ok; logic [7:0] sec; logic prot;} ev_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, otpW;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic quadMode = 1'b0, otpMode = 1'b0, wpN = 1'b1, factoryLock = 1'b1, okLvl = 1'b1;
  logic [3:0] blockProtectLevel = 4'h0;
  logic [10:0] ev = '0;
  logic [7:0] securityStatus, wrData;
  logic writeEnableLatch, advancedCmdsEnabled, arrayAccessOk, eraseProtected, writeStart;
  int failures = 0, cmp_count = 0, starts = 0;
  row_t rows [6] = '{'{3'h0, 1'b0, 8'h01, 1'b1}, '{3'h1, 1'b0, 8'h01, 1'b1}, '{3'h2, 1'b0, 8'h03, 1'b0},
    '{3'h0, 1'b1, 8'h03, 1'b1}, '{3'h3, 1'b1, 8'h83, 1'b0}, '{3'h1, 1'b0, 8'h83, 1'b0}};
  ev_t evs [13] = '{'{4'hA, 1'b0, 8'h83, 1'b0}, '{4'h0, 1'b0, 8'hC3, 1'b0}, '{4'h0, 1'b1, 8'h83, 1'b0},
    '{4'h1, 1'b0, 8'hA3, 1'b0}, '{4'h1, 1'b1, 8'h83, 1'b0}, '{4'h2, 1'b0, 8'h8B, 1'b0},
    '{4'h3, 1'b0, 8'h83, 1'b0}, '{4'h4, 1'b0, 8'h87, 1'b0}, '{4'h5, 1'b0, 8'h83, 1'b0},
    '{4'h9, 1'b0, 8'h83, 1'b1}, '{4'h8, 1'b0, 8'h83, 1'b0}, '{4'h6, 1'b0, 8'h83, 1'b1},
    '{4'h7, 1'b0, 8'h83, 1'b0}};

  flash_link_if lnk ();
  flash_sec_host flash_sec_host_i (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .link(lnk.host));
  flash_sec_device flash_sec_device_i (.mclk, .rst, .link(lnk.device), .quadMode, .otpMode, .wpN,
    .blockProtectLevel, .factoryLock, .eraseAddr(24'h0), .eraseDone(ev[0]), .eraseOk(okLvl),
    .programDone(ev[1]), .programOk(okLvl), .eraseSuspend(ev[2]), .eraseResume(ev[3]),
    .programSuspend(ev[4]), .programResume(ev[5]), .lockAddr(24'h0), .solidSet(ev[6]),
    .solidClearAll(ev[7]), .dynamicWrite(ev[8]), .dynamicValue(okLvl), .gangLock(ev[9]),
    .gangUnlock(ev[10]), .securityStatus, .writeEnableLatch, .advancedCmdsEnabled, .arrayAccessOk,
    .otpWritable(otpW), .eraseProtected, .writeStart, .writeAddr(), .writeData(wrData));
  flash_link_sva flash_link_sva_i (.mclk, .rst, .csN(lnk.csN), .sclk(lnk.sclk), .hostIoOe(lnk.hostIoOe),
    .devIo(lnk.devIo), .devIoOe(lnk.devIoOe));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (writeStart === 1'b1) starts <= starts + 1;
  end

  task automatic final_report();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Entered just after a rising edge; releases and lets one edge pass
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    if (n == 20) begin
      failures++;
      final_report();
    end
  endtask : apb

  task automatic cmd(input logic [2:0] k, input logic q);
    int n;
    n = 0;
    apb(1'b1, REG_COMMAND, {23'h0, q, 5'h0, k});
    repeat (2) @(posedge mclk);
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 400) begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    if (n == 400) begin
      failures++;
      final_report();
    end
  endtask : cmd

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(securityStatus, 8'h01)
    `CHK(eraseProtected, 1'b0)
    blockProtectLevel <= 4'h8;
    repeat (2) @(posedge mclk);
    `CHK(eraseProtected, 1'b1)
    blockProtectLevel <= 4'h0;
    apb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(err, 1'b1)
    cmd(KIND_WRITE_SECURITY, 1'b0);
    `CHK(rd[1], 1'b1)
    foreach (rows[i]) begin
      quadMode <= rows[i].quad;
      cmd(rows[i].kind, rows[i].quad);
      `CHK(writeEnableLatch, rows[i].write_enable_latch)
      cmd(KIND_READ_SECURITY, rows[i].quad);
      `CHK(rd[15:8], rows[i].sec)
    end
    `CHK(eraseProtected, 1'b1)
    `CHK(otpW, 1'b0)
    `CHK(advancedCmdsEnabled, 1'b1)
    foreach (evs[i]) begin
      okLvl <= evs[i].ok;
      ev <= 11'h001 << evs[i].idx;
      @(posedge mclk);
      ev <= '0;
      repeat (4) @(posedge mclk);
      `CHK(securityStatus, evs[i].sec)
      `CHK(eraseProtected, evs[i].prot)
    end
    wpN <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(eraseProtected, 1'b1)
    cmd(KIND_WRITE_ENABLE, 1'b0);
    apb(1'b1, REG_WDATA, 32'h5A);
    cmd(KIND_PAGE_WRITE, 1'b0);
    `CHK(starts, 0)
    `CHK(securityStatus, 8'hA3)
    // Unprotected target in four-line mode must start the write
    wpN <= 1'b1;
    cmd(KIND_WRITE_ENABLE, 1'b0);
    apb(1'b1, REG_WDATA, 32'hC3);
    quadMode <= 1'b1;
    cmd(KIND_PAGE_WRITE, 1'b1);
    `CHK(starts, 1)
    `CHK(wrData, 8'hC3)
    `CHK(writeEnableLatch, 1'b0)
    quadMode <= 1'b0;
    otpMode <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(arrayAccessOk, 1'b0)
    rst <= 1'b1;
    factoryLock <= 1'b0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(securityStatus, 8'h00)
    `CHK(writeEnableLatch, 1'b0)
    final_report();
  end
endmodule : test_flash_security_protect_select
